// [hdl/scsc_top.sv]
// System clock source selection, prescaler and peripheral gating with its bus slave.
`include "scsc_params.svh"
`default_nettype none

module scsc_top #(
    parameter int ADDR_W = 32
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic slow_osc_tick,
    input wire logic fast_osc_tick,
    input wire logic idle_mode,
    output logic sys_clk_en,
    output logic periph_clk_en,
    output logic fast_osc_run,
    output logic slow_crystal_select,
    output logic fast_crystal_select
);
    import scsc_pkg::*;

    // ------------------------------------------------------------------
    // Oscillator tick synchronisers.
    // ------------------------------------------------------------------
    scsc_tick_if slow_tick ();
    scsc_tick_if fast_tick ();

    scsc_tick_sync u_slow_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .osc_pin(slow_osc_tick),
        .tick(slow_tick.src)
    );

    scsc_tick_sync u_fast_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .osc_pin(fast_osc_tick),
        .tick(fast_tick.src)
    );

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    scsc_ctrl_t ctrl;
    scsc_ctrl_t next_ctrl;
    scsc_ctrl_t wdata;
    logic wr_ctrl;
    logic next_wr_ctrl;
    logic [31:0] next_hrdata;
    logic act_sel;
    logic next_act_sel;
    scsc_div_t act_div;
    scsc_div_t next_act_div;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic next_sys_clk_en;
    logic next_periph_clk_en;
    logic next_fast_osc_run;
    logic tick;
    logic boundary;
    logic [3:0] term;
    logic addr_phase;

    // Terminal count of the divider for a prescaler code.
    function automatic logic [3:0] div_term(input scsc_div_t code);
        logic [3:0] t;
        t = `SCSC_TERM_BY1;
        case (code)
            `SCSC_DIV_BY16: t = `SCSC_TERM_BY16;
            `SCSC_DIV_BY4: t = `SCSC_TERM_BY4;
            `SCSC_DIV_BY2: t = `SCSC_TERM_BY2;
            default: t = `SCSC_TERM_BY1;
        endcase
        return t;
    endfunction

    // Selected source tick and the end of the current output period.
    assign tick = act_sel ? fast_tick.pulse : slow_tick.pulse;
    assign term = div_term(act_div);
    assign boundary = tick && (cnt >= term);
    assign wdata = scsc_ctrl_t'(hwdata[`SCSC_REG_W-1:0]);
    assign addr_phase = hsel && hready && htrans[`SCSC_HTRANS_ACTIVE_BIT];

    // ------------------------------------------------------------------
    // Bus slave: zero wait states, always OKAY.
    // ------------------------------------------------------------------

    // A write is taken in its address phase and applied in its data phase.
    // Read data are built from next_ctrl so a read right behind a write
    // already sees the written value.
    always_comb begin
        next_wr_ctrl = addr_phase && hwrite && (haddr == ADDR_W'(`SCSC_CTRL_OFFSET));
        next_hrdata = 32'h0000_0000;
        if (addr_phase && !hwrite && (haddr == ADDR_W'(`SCSC_CTRL_OFFSET))) begin
            next_hrdata = {24'h00_0000, next_ctrl};
        end else if (addr_phase && !hwrite && (haddr == ADDR_W'(`SCSC_STAT_OFFSET))) begin
            next_hrdata = {28'h000_0000, next_fast_osc_run, next_act_div, next_act_sel};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_ctrl <= 1'b0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= `SCSC_HRESP_OKAY;
        end else begin
            wr_ctrl <= next_wr_ctrl;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= `SCSC_HRESP_OKAY;
        end
    end

    // ------------------------------------------------------------------
    // Control register with mode-gated fields.
    // ------------------------------------------------------------------

    // Each gated field is checked on its own; a refused field keeps its value and
    // the rest of the same write still lands. Gating on both the written
    // select and the select in use closes the window where a switch is
    // still waiting for the period boundary.
    always_comb begin
        next_ctrl = ctrl;
        if (wr_ctrl) begin
            if (ctrl.system_source_select && act_sel) begin
                next_ctrl.slow_source_type = wdata.slow_source_type;
            end
            if (!ctrl.system_source_select && !act_sel) begin
                next_ctrl.fast_source_type = wdata.fast_source_type;
            end
            next_ctrl.idle_peripheral_clock_stop = wdata.idle_peripheral_clock_stop;
            if (!ctrl.system_source_select && !act_sel) begin
                next_ctrl.fast_oscillator_stop = wdata.fast_oscillator_stop;
            end
            if (!ctrl.fast_oscillator_stop) begin
                next_ctrl.system_source_select = wdata.system_source_select;
            end
            next_ctrl.system_clock_divider = wdata.system_clock_divider;
        end
        next_ctrl.reserved5 = 1'b0;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ctrl <= scsc_ctrl_t'(`SCSC_CTRL_RESET);
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ------------------------------------------------------------------
    // System clock enable generation.
    // ------------------------------------------------------------------

    // Source and divider are only taken over at a period boundary, so the
    // output period never mixes two settings and no pulse comes short at a divider change.
    always_comb begin
        next_cnt = cnt;
        next_act_sel = act_sel;
        next_act_div = act_div;
        next_sys_clk_en = 1'b0;
        next_periph_clk_en = 1'b0;
        if (boundary) begin
            next_cnt = 4'h0;
            next_sys_clk_en = 1'b1;
            next_periph_clk_en = !(idle_mode && ctrl.idle_peripheral_clock_stop);
            next_act_sel = ctrl.system_source_select;
            next_act_div = ctrl.system_clock_divider;
        end else if (tick) begin
            next_cnt = cnt + 4'h1;
        end
        // The fast oscillator stops only once the system really runs slow.
        next_fast_osc_run = !(ctrl.fast_oscillator_stop && !act_sel);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt <= 4'h0;
            act_sel <= 1'b0;
            act_div <= `SCSC_DIV_BY1;
            sys_clk_en <= 1'b0;
            periph_clk_en <= 1'b0;
            fast_osc_run <= 1'b1;
            slow_crystal_select <= 1'b0;
            fast_crystal_select <= 1'b0;
        end else begin
            cnt <= next_cnt;
            act_sel <= next_act_sel;
            act_div <= next_act_div;
            sys_clk_en <= next_sys_clk_en;
            periph_clk_en <= next_periph_clk_en;
            fast_osc_run <= next_fast_osc_run;
            slow_crystal_select <= ctrl.slow_source_type;
            fast_crystal_select <= ctrl.fast_source_type;
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    sequence seq_end_of_period;
        tick && (cnt >= term);
    endsequence

    sequence seq_mid_period;
        tick && (cnt < term);
    endsequence

    AST_SLOW_TYPE_GATED: assert property (
        wr_ctrl && !(ctrl.system_source_select && act_sel)
        |=> ctrl.slow_source_type == $past(ctrl.slow_source_type))
        else $error("slow source type changed outside fast mode");

    AST_FAST_TYPE_GATED: assert property (
        wr_ctrl && (ctrl.system_source_select || act_sel)
        |=> ctrl.fast_source_type == $past(ctrl.fast_source_type))
        else $error("fast source type changed outside slow mode");

    AST_PERIPH_IDLE_STOP: assert property (
        periph_clk_en |-> sys_clk_en && !$past(idle_mode && ctrl.idle_peripheral_clock_stop))
        else $error("peripheral clock ran while stopped in idle");

    AST_FAST_OSC_STOP: assert property (
        ctrl.fast_oscillator_stop && !act_sel |=> !fast_osc_run)
        else $error("fast oscillator kept running while stopped");

    AST_FSTOP_GATED: assert property (
        wr_ctrl && (ctrl.system_source_select || act_sel)
        |=> $stable(ctrl.fast_oscillator_stop))
        else $error("fast stop bit changed outside slow mode");

    AST_SELECT_GATED: assert property (
        wr_ctrl && ctrl.fast_oscillator_stop |=> $stable(ctrl.system_source_select))
        else $error("source select changed while fast clock stopped");

    AST_SOURCE_TICK: assert property (
        sys_clk_en |-> $past(act_sel ? fast_tick.pulse : slow_tick.pulse))
        else $error("system clock pulse without a tick of the selected source");

    AST_DIVIDER_PULSE: assert property (
        seq_end_of_period |=> sys_clk_en)
        else $error("no system clock pulse at the end of a period");

    AST_DIVIDER_QUIET: assert property (
        seq_mid_period |=> !sys_clk_en && cnt == $past(cnt) + 4'h1)
        else $error("system clock pulse inside a period");

    AST_OTHER_FIELDS_UPDATE: assert property (
        wr_ctrl |=> ctrl.system_clock_divider == $past(wdata.system_clock_divider)
            && ctrl.idle_peripheral_clock_stop == $past(wdata.idle_peripheral_clock_stop))
        else $error("allowed field did not take the written value");

    AST_SWITCH_AT_BOUNDARY: assert property (
        !$stable(act_sel) || !$stable(act_div) |-> $past(boundary) && $past(cnt) >= $past(term))
        else $error("source or divider switched inside a period");

endmodule

`default_nettype wire

// [hdl/scsc_params.svh]
// Offsets, data width, reset value and codes of the system clock select control.
`ifndef SCSC_PARAMS_SVH
`define SCSC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte addresses on the bus.
// ----------------------------------------------------------------------
`define SCSC_CTRL_OFFSET 8'hd8
`define SCSC_STAT_OFFSET 8'hdc

// ----------------------------------------------------------------------
// Control register reset value and data width.
// ----------------------------------------------------------------------
`define SCSC_CTRL_RESET 8'h03
`define SCSC_REG_W 8

// ----------------------------------------------------------------------
// Divider codes and the terminal count of each.
// ----------------------------------------------------------------------
`define SCSC_DIV_BY16 2'h0
`define SCSC_DIV_BY4 2'h1
`define SCSC_DIV_BY2 2'h2
`define SCSC_DIV_BY1 2'h3
`define SCSC_TERM_BY16 4'hf
`define SCSC_TERM_BY4 4'h3
`define SCSC_TERM_BY2 4'h1
`define SCSC_TERM_BY1 4'h0

// ----------------------------------------------------------------------
// Bus codes.
// ----------------------------------------------------------------------
`define SCSC_HTRANS_ACTIVE_BIT 1
`define SCSC_HRESP_OKAY 1'b0

`endif

// [hdl/scsc_pkg.sv]
// Types shared by the system clock select control files.
`default_nettype none

package scsc_pkg;

    // Prescaler code held in the control register.
    typedef logic [1:0] scsc_div_t;

    // Layout of the control register, bit 7 down to bit 0.
    typedef struct packed {
        logic slow_source_type;
        logic fast_source_type;
        logic reserved5;
        logic idle_peripheral_clock_stop;
        logic fast_oscillator_stop;
        logic system_source_select;
        scsc_div_t system_clock_divider;
    } scsc_ctrl_t;

endpackage

`default_nettype wire

// [hdl/scsc_tick_if.sv]
// Carrier of one synchronised oscillator tick between the sync block and the top.
`default_nettype none

interface scsc_tick_if;
    logic pulse;
    modport src (output pulse);
    modport dst (input pulse);
endinterface

`default_nettype wire

// [hdl/scsc_tick_sync.sv]
// Two-flop synchroniser with rising edge detector for one oscillator tick pin.
`default_nettype none

module scsc_tick_sync (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic osc_pin,
    scsc_tick_if.src tick
);
    logic meta;
    logic stable;
    logic prev;
    logic next_pulse;

    // Edge detect looks only at the second stage, never at the first.
    always_comb begin
        next_pulse = stable & ~prev;
    end

    // The first stage feeds only the second stage.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            // The chain is parked high so that a pin which is already high at
            // release is not taken for a fresh edge. That false tick would cut
            // short the first divided period after reset.
            meta <= 1'b1;
            stable <= 1'b1;
            prev <= 1'b1;
            tick.pulse <= 1'b0;
        end else begin
            meta <= osc_pin;
            stable <= meta;
            prev <= stable;
            tick.pulse <= next_pulse;
        end
    end
endmodule

`default_nettype wire

// [test/scsc_top_tb.sv]
// Self-checking testbench for the system clock select control block.
`include "scsc_params.svh"
`default_nettype none

module scsc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------------
    // Signals, oscillator periods and bookkeeping.
    // ----------------------------------------------------------------------
    localparam int SLOW_P = 8;
    localparam int FAST_P = 4;
    logic ref_clk, reset, hsel, hwrite, idle_mode, slow_osc_tick, fast_osc_tick, rd_pend;
    logic dp_pend;
    logic [31:0] haddr, hwdata, hrdata, seed;
    logic [1:0] htrans, fast_cnt;
    logic [2:0] hsize, slow_cnt;
    logic hreadyout, hresp, sys_clk_en, periph_clk_en, fast_osc_run;
    logic slow_crystal_select, fast_crystal_select;
    wire hready;
    logic [31:0] exp_q[$];
    int error_cnt = 0;
    int total_checks = 0;
    int g, g1, g2, s, p, old_div, new_div;

    assign hready = hreadyout;

    scsc_top #(.ADDR_W(32)) u_scsc_top (
        .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .slow_osc_tick(slow_osc_tick), .fast_osc_tick(fast_osc_tick), .idle_mode(idle_mode),
        .sys_clk_en(sys_clk_en), .periph_clk_en(periph_clk_en), .fast_osc_run(fast_osc_run),
        .slow_crystal_select(slow_crystal_select), .fast_crystal_select(fast_crystal_select)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Oscillator pins; a stopped fast oscillator leaves its pin still, as silicon would.
    always @(posedge ref_clk) begin
        slow_cnt <= slow_cnt + 3'h1;
        slow_osc_tick <= (slow_cnt < 3'h4);
        if (fast_osc_run === 1'b1) begin
            fast_cnt <= fast_cnt + 2'h1;
        end
        fast_osc_tick <= fast_cnt[1];
    end

    // Bus monitor: the data phase follows an accepted address phase by one edge.
    // Every data phase must end with an OKAY response, reads and writes alike.
    always @(posedge ref_clk) begin
        if (rd_pend === 1'b1) begin
            check("hrdata", exp_q.pop_front(), hrdata);
        end
        if (dp_pend === 1'b1) begin
            check("hresp", {31'h0, `SCSC_HRESP_OKAY}, {31'h0, hresp});
        end
        rd_pend <= (hsel === 1'b1) && (hready === 1'b1) && (htrans[1] === 1'b1) && !hwrite;
        dp_pend <= (hsel === 1'b1) && (hready === 1'b1) && (htrans[1] === 1'b1);
    end

    // ----------------------------------------------------------------------
    // Comparison, bus and measurement tasks.
    // ----------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_count(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Bounded wait for hready at a rising edge; a hung slave ends the run.
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge ref_clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                error_cnt++;
                $display("[FAIL] hready expected 1 seen %b", hready);
                tally_and_finish();
            end
            @(posedge ref_clk);
        end
    endtask

    // Entered just after a rising edge, so requests may follow each other back to back.
    task automatic bus_req(input logic [7:0] addr, input logic wr, input logic [31:0] data);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, addr};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= data;
        wait_ready();
    endtask

    task automatic bus_read(input logic [7:0] addr, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus_req(addr, 1'b0, 32'h0000_0000);
    endtask

    // Cycles to the next system clock pulse, counted at falling edges.
    task automatic next_pulse(output int cycles);
        cycles = 1;
        @(negedge ref_clk);
        while (sys_clk_en !== 1'b1) begin
            cycles++;
            if (cycles > 1000) begin
                error_cnt++;
                $display("[FAIL] sys_clk_en expected pulse seen none");
                tally_and_finish();
            end
            @(negedge ref_clk);
        end
    endtask

    // Counts both enables over a window, optionally toggling Idle at random.
    task automatic count_pulses(input int n, input bit rnd, output int ns, output int np);
        ns = 0;
        np = 0;
        repeat (n) begin
            @(posedge ref_clk);
            if (rnd) begin
                seed = lfsr(seed);
                idle_mode <= seed[0];
            end
            @(negedge ref_clk);
            ns += int'(sys_clk_en === 1'b1);
            np += int'(periph_clk_en === 1'b1);
        end
    endtask

    // ----------------------------------------------------------------------
    // Main sequence.
    // ----------------------------------------------------------------------
    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        idle_mode = 1'b0;
        slow_osc_tick = 1'b0;
        fast_osc_tick = 1'b0;
        slow_cnt = 3'h0;
        fast_cnt = 2'h0;
        rd_pend = 1'b0;
        dp_pend = 1'b0;
        seed = 32'h774f_d003;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        // Reset values, and an unmapped place that must swallow writes.
        bus_read(`SCSC_CTRL_OFFSET, 32'h0000_0003);
        bus_read(`SCSC_STAT_OFFSET, 32'h0000_000e);
        bus_req(8'h40, 1'b1, 32'h0000_00ff);
        bus_read(8'h40, 32'h0000_0000);
        bus_read(`SCSC_CTRL_OFFSET, 32'h0000_0003);
        check("fast_crystal_select", 32'h0, {31'h0, fast_crystal_select});
        $display("test reset finished");
        // Every divider code; the period spanning a change is whole, never shortened.
        old_div = 1;
        for (int code = 0; code < 4; code++) begin
            new_div = (code == 0) ? 16 : (code == 1) ? 4 : (code == 2) ? 2 : 1;
            bus_req(`SCSC_CTRL_OFFSET, 1'b1, code);
            next_pulse(g);
            next_pulse(g1);
            next_pulse(g2);
            check_count("divider gap", new_div * SLOW_P, g2);
            check_count("switch gap", 1, int'(g1 == old_div * SLOW_P || g1 == new_div * SLOW_P));
            old_div = new_div;
            @(posedge ref_clk);
        end
        $display("test divider finished");
        // Field gating in Slow mode: a refused field leaves its neighbours free.
        bus_req(`SCSC_CTRL_OFFSET, 1'b1, 32'h0000_00c3);
        bus_read(`SCSC_CTRL_OFFSET, 32'h0000_0043);
        check("fast_crystal_select", 32'h1, {31'h0, fast_crystal_select});
        bus_req(`SCSC_CTRL_OFFSET, 1'b1, 32'h0000_004b);
        bus_req(`SCSC_CTRL_OFFSET, 1'b1, 32'h0000_004f);
        bus_read(`SCSC_CTRL_OFFSET, 32'h0000_004b);
        check("fast_osc_run", 32'h0, {31'h0, fast_osc_run});
        bus_read(`SCSC_STAT_OFFSET, 32'h0000_0006);
        bus_req(`SCSC_CTRL_OFFSET, 1'b1, 32'h0000_0043);
        bus_req(`SCSC_CTRL_OFFSET, 1'b1, 32'h0000_0047);
        repeat (4) next_pulse(g);
        next_pulse(g);
        check_count("fast gap", FAST_P, g);
        @(posedge ref_clk);
        bus_read(`SCSC_STAT_OFFSET, 32'h0000_000f);
        // Field gating in Fast mode.
        bus_req(`SCSC_CTRL_OFFSET, 1'b1, 32'h0000_00cf);
        bus_read(`SCSC_CTRL_OFFSET, 32'h0000_00c7);
        bus_req(`SCSC_CTRL_OFFSET, 1'b1, 32'h0000_0087);
        bus_read(`SCSC_CTRL_OFFSET, 32'h0000_00c7);
        check("slow_crystal_select", 32'h1, {31'h0, slow_crystal_select});
        check("fast_osc_run", 32'h1, {31'h0, fast_osc_run});
        $display("test gating finished");
        // Peripheral clocks halt only in Idle with the stop bit set.
        bus_req(`SCSC_CTRL_OFFSET, 1'b1, 32'h0000_00d7);
        idle_mode <= 1'b1;
        repeat (8) @(posedge ref_clk);
        count_pulses(64, 1'b0, s, p);
        check_count("idle sys pulses", 64 / FAST_P, s);
        check_count("idle periph pulses", 0, p);
        idle_mode <= 1'b0;
        repeat (8) @(posedge ref_clk);
        count_pulses(64, 1'b0, s, p);
        check_count("run periph pulses", s, p);
        @(posedge ref_clk);
        bus_req(`SCSC_CTRL_OFFSET, 1'b1, 32'h0000_00c7);
        count_pulses(200, 1'b1, s, p);
        check_count("random idle periph pulses", s, p);
        idle_mode <= 1'b0;
        $display("test idle finished");
        tally_and_finish();
    end

endmodule

`default_nettype wire
